/* core/psr_defs.vh */
// Constants for the suspend/resume and SMI sequencing block
`ifndef PSR_DEFS_VH
`define PSR_DEFS_VH
// Configuration indices
`define PSR_IDX_WAKE_MASK   8'h08
`define PSR_IDX_IO_WAIT     8'h61
`define PSR_IDX_REVISION    8'h64
`define PSR_IDX_ACT_MASK    8'h75
`define PSR_IDX_CTRL_B      8'h77
`define PSR_IDX_EVT_EN      8'h82
`define PSR_IDX_S2S_TMO     8'h86
`define PSR_IDX_CLK_SET     8'h8F
`define PSR_IDX_RSVD        8'h9D
`define PSR_IDX_THROTTLE    8'h9F
`define PSR_IDX_REQ_STAT    8'hA2
`define PSR_IDX_SMI_CAUSE   8'hA5
`define PSR_IDX_PMU_CTL1    8'hA7
`define PSR_IDX_SMM_UPPER   8'hA9
`define PSR_IDX_SMM_LOWER   8'hAA
`define PSR_IDX_MISC5       8'hB3
`define PSR_IDX_MISC3       8'hBA
// Field positions
`define PSR_BIT_RESUME_EN   0
`define PSR_BIT_S2S_EN      3
`define PSR_BIT_SMI_SEL     7
`define PSR_BIT_IN_SMM      7
`define PSR_BIT_CAUSE_RES   0
`define PSR_BIT_CAUSE_S2S   3
`define PSR_BIT_AUTO_LS_EN  3
`define PSR_BIT_HS_CLK_EN   6
`define PSR_BIT_SELF_REF    3
`define PSR_BIT_DRAM_KEEP   2
// Fields kept across micro power-off
`define PSR_KEEP_REVISION   8'h03
`define PSR_KEEP_CLK_SET    8'hFF
`define PSR_KEEP_RSVD       8'hF7
`define PSR_KEEP_PMU_CTL1   8'h02
`define PSR_KEEP_MISC5      8'h08
`define PSR_KEEP_MISC3      8'h1F
// Reset values
`define PSR_RST_REG         8'h00
`define PSR_RST_REVISION    8'h03
// Mode codes
`define PSR_MODE_HS         3'h0
`define PSR_MODE_LS         3'h1
`define PSR_MODE_DOZE       3'h2
`define PSR_MODE_SLEEP      3'h3
`define PSR_MODE_SUSPEND    3'h4
`define PSR_MODE_OFF        3'h5
`endif

/* core/psr_pmu_seq.v */
// Suspend/resume key, SMI request and power sequencing logic
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.vh"

module psr_pmu_seq (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       suspend_resume_key_input,
   input  wire       power_off_request_pin_n,
   input  wire       refresh_pulse,
   input  wire       cpu_in_smm,
   input  wire [7:0] wake_event_in,
   input  wire [7:0] activity_in,
   input  wire       cfg_index_we,
   input  wire       cfg_data_we,
   input  wire       cfg_data_re,
   input  wire [7:0] cfg_wdata,
   output reg  [7:0] cfg_rdata_q,
   output reg        smi_req_q,
   output reg        nmi_req_q,
   output reg  [2:0] pmu_mode_q,
   output reg        temp_on_q,
   output reg        cpu_clk_run_q,
   output reg        cpu_low_speed_q,
   output reg        hs_clk_allow_q,
   output reg        refresh_toggle_q,
   output reg        micro_power_off_q,
   output reg        self_refresh_sel_q,
   output reg        dram_retain_q,
   output reg  [9:0] smm_base_q
);

   // Configuration storage
   reg [7:0] idx_q;
   reg [7:0] wake_mask_q;
   reg [7:0] io_wait_q;
   reg [7:0] revision_q;
   reg [7:0] act_mask_q;
   reg [7:0] ctrl_b_q;
   reg [7:0] evt_en_q;
   reg [7:0] s2s_tmo_q;
   reg [7:0] clk_set_q;
   reg [7:0] rsvd_q;
   reg [7:0] throttle_q;
   reg [7:0] pmu_ctl1_q;
   reg [7:0] smm_upper_q;
   reg [7:0] smm_lower_q;
   reg [7:0] misc5_q;
   reg [7:0] misc3_q;

   // Sequencing state
   reg [7:0] cause_q;
   reg       req_q;
   reg [2:0] mode_q;
   reg       stepping_q;
   reg       wake_pend_q;
   reg       buffered_q;
   reg       exit_temp_q;
   reg [7:0] s2s_cnt_q;
   reg [3:0] thr_cnt_q;
   reg       thr_low_q;

   // Synchronisers: first stage is read only by the second
   reg [1:0] key_sync_q;
   reg       key_last_q;
   reg [1:0] ref_sync_q;
   reg       ref_last_q;

   // Masks a register with the field kept across micro power-off
   function [7:0] keep_bits;
      input [7:0] value;
      input [7:0] keep;
      begin
         keep_bits = value & keep;
      end
   endfunction

   // True in Sleep, Suspend or Off
   function is_asleep;
      input [2:0] mode;
      begin
         is_asleep = (mode == `PSR_MODE_SLEEP) || (mode == `PSR_MODE_SUSPEND) ||
                     (mode == `PSR_MODE_OFF);
      end
   endfunction

   // Input synchronisers and edge detectors
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         key_sync_q <= 2'h0;
         key_last_q <= 1'b0;
         ref_sync_q <= 2'h0;
         ref_last_q <= 1'b0;
      end else begin
         key_sync_q <= {key_sync_q[0], suspend_resume_key_input};
         key_last_q <= key_sync_q[1];
         ref_sync_q <= {ref_sync_q[0], refresh_pulse};
         ref_last_q <= ref_sync_q[1];
      end
   end

   wire key_edge = key_sync_q[1] & ~key_last_q;
   wire ref_tick = ref_sync_q[1] & ~ref_last_q;

   // Index/data access decode
   wire wr_cause = cfg_data_we && (idx_q == `PSR_IDX_SMI_CAUSE);
   wire wr_stat  = cfg_data_we && (idx_q == `PSR_IDX_REQ_STAT);
   wire asleep   = is_asleep(mode_q);
   wire running  = !asleep;

   // Other wake sources only count when unmasked
   wire other_wake = |(wake_event_in & ~wake_mask_q) |
                     |(activity_in & ~act_mask_q);

   // Sleep-to-suspend expiry; a zero timeout never expires
   wire s2s_expire = ref_tick && (mode_q == `PSR_MODE_SLEEP) && !temp_on_q &&
                     (s2s_tmo_q != 8'h00) && (s2s_cnt_q + 8'h01 >= s2s_tmo_q);

   // A resume input, taken while asleep and not in Temporary-On
   wire resume_in = key_edge && asleep && !temp_on_q && !stepping_q;

   // Wake into high speed on the refresh after a resume
   wire do_wake = ref_tick && wake_pend_q;

   wire set_res = do_wake && evt_en_q[`PSR_BIT_RESUME_EN];
   wire set_s2s = s2s_expire && evt_en_q[`PSR_BIT_S2S_EN];
   wire new_req = set_res | set_s2s;

   // Throttling allowed only with both enables and in high speed
   wire thr_on = ctrl_b_q[`PSR_BIT_AUTO_LS_EN] &&
                 io_wait_q[`PSR_BIT_HS_CLK_EN] &&
                 (mode_q == `PSR_MODE_HS);

   // Configuration registers, with micro power-off partial clear
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         idx_q       <= `PSR_RST_REG;
         wake_mask_q <= `PSR_RST_REG;
         io_wait_q   <= `PSR_RST_REG;
         revision_q  <= `PSR_RST_REVISION;
         act_mask_q  <= `PSR_RST_REG;
         ctrl_b_q    <= `PSR_RST_REG;
         evt_en_q    <= `PSR_RST_REG;
         s2s_tmo_q   <= `PSR_RST_REG;
         clk_set_q   <= `PSR_RST_REG;
         rsvd_q      <= `PSR_RST_REG;
         throttle_q  <= `PSR_RST_REG;
         pmu_ctl1_q  <= `PSR_RST_REG;
         smm_upper_q <= `PSR_RST_REG;
         smm_lower_q <= `PSR_RST_REG;
         misc5_q     <= `PSR_RST_REG;
         misc3_q     <= `PSR_RST_REG;
      end else if (!power_off_request_pin_n) begin
         // Cold boot except kept fields; retention bit is in the kept set
         idx_q       <= `PSR_RST_REG;
         wake_mask_q <= `PSR_RST_REG;
         io_wait_q   <= `PSR_RST_REG;
         revision_q  <= keep_bits(revision_q, `PSR_KEEP_REVISION);
         act_mask_q  <= `PSR_RST_REG;
         ctrl_b_q    <= `PSR_RST_REG;
         evt_en_q    <= `PSR_RST_REG;
         s2s_tmo_q   <= `PSR_RST_REG;
         clk_set_q   <= keep_bits(clk_set_q, `PSR_KEEP_CLK_SET);
         rsvd_q      <= keep_bits(rsvd_q, `PSR_KEEP_RSVD);
         throttle_q  <= `PSR_RST_REG;
         pmu_ctl1_q  <= keep_bits(pmu_ctl1_q, `PSR_KEEP_PMU_CTL1);
         smm_upper_q <= `PSR_RST_REG;
         smm_lower_q <= `PSR_RST_REG;
         misc5_q     <= keep_bits(misc5_q, `PSR_KEEP_MISC5);
         misc3_q     <= keep_bits(misc3_q, `PSR_KEEP_MISC3);
      end else begin
         if (cfg_index_we) begin
            idx_q <= cfg_wdata;
         end
         if (cfg_data_we) begin
            case (idx_q)
               `PSR_IDX_WAKE_MASK: wake_mask_q <= cfg_wdata;
               `PSR_IDX_IO_WAIT:   io_wait_q   <= cfg_wdata;
               `PSR_IDX_REVISION:  revision_q  <= {1'b0, cfg_wdata[6:0]};
               `PSR_IDX_ACT_MASK:  act_mask_q  <= cfg_wdata;
               `PSR_IDX_CTRL_B:    ctrl_b_q    <= cfg_wdata;
               `PSR_IDX_EVT_EN:    evt_en_q    <= cfg_wdata;
               `PSR_IDX_S2S_TMO:   s2s_tmo_q   <= cfg_wdata;
               `PSR_IDX_CLK_SET:   clk_set_q   <= cfg_wdata;
               `PSR_IDX_RSVD:      rsvd_q      <= cfg_wdata;
               `PSR_IDX_THROTTLE:  throttle_q  <= cfg_wdata;
               `PSR_IDX_PMU_CTL1:  pmu_ctl1_q  <= cfg_wdata;
               `PSR_IDX_SMM_UPPER: smm_upper_q <= cfg_wdata;
               `PSR_IDX_SMM_LOWER: smm_lower_q <= cfg_wdata;
               `PSR_IDX_MISC5:     misc5_q     <= cfg_wdata;
               `PSR_IDX_MISC3:     misc3_q     <= cfg_wdata;
               default: ;
            endcase
         end
      end
   end

   // Read data; bit 7 of revision is live handler status
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg_rdata_q <= 8'h00;
      end else if (cfg_data_re) begin
         case (idx_q)
            `PSR_IDX_WAKE_MASK: cfg_rdata_q <= wake_mask_q;
            `PSR_IDX_IO_WAIT:   cfg_rdata_q <= io_wait_q;
            `PSR_IDX_REVISION:  cfg_rdata_q <= {cpu_in_smm, revision_q[6:0]};
            `PSR_IDX_ACT_MASK:  cfg_rdata_q <= act_mask_q;
            `PSR_IDX_CTRL_B:    cfg_rdata_q <= ctrl_b_q;
            `PSR_IDX_EVT_EN:    cfg_rdata_q <= evt_en_q;
            `PSR_IDX_S2S_TMO:   cfg_rdata_q <= s2s_tmo_q;
            `PSR_IDX_CLK_SET:   cfg_rdata_q <= clk_set_q;
            `PSR_IDX_RSVD:      cfg_rdata_q <= rsvd_q;
            `PSR_IDX_THROTTLE:  cfg_rdata_q <= throttle_q;
            `PSR_IDX_REQ_STAT:  cfg_rdata_q <= {7'h00, req_q};
            `PSR_IDX_SMI_CAUSE: cfg_rdata_q <= cause_q;
            `PSR_IDX_PMU_CTL1:  cfg_rdata_q <= pmu_ctl1_q;
            `PSR_IDX_SMM_UPPER: cfg_rdata_q <= smm_upper_q;
            `PSR_IDX_SMM_LOWER: cfg_rdata_q <= smm_lower_q;
            `PSR_IDX_MISC5:     cfg_rdata_q <= misc5_q;
            `PSR_IDX_MISC3:     cfg_rdata_q <= misc3_q;
            default:            cfg_rdata_q <= 8'h00;
         endcase
      end
   end

   // Cause flags and held request; a new event wins over the clear
   always @(posedge sys_clk) begin
      if (!rst_n || !power_off_request_pin_n) begin
         cause_q <= 8'h00;
         req_q   <= 1'b0;
      end else begin
         cause_q <= (wr_cause ? 8'h00 : cause_q) |
                    {4'h0, set_s2s, 2'h0, set_res};
         req_q   <= (wr_stat ? 1'b0 : req_q) | new_req;
      end
   end

   // Mode sequencer, stepped only by refresh
   always @(posedge sys_clk) begin
      if (!rst_n || !power_off_request_pin_n) begin
         mode_q      <= `PSR_MODE_HS;
         stepping_q  <= 1'b0;
         wake_pend_q <= 1'b0;
         buffered_q  <= 1'b0;
         exit_temp_q <= 1'b0;
         temp_on_q   <= 1'b0;
         s2s_cnt_q   <= 8'h00;
      end else begin
         // Suspend input starts the walk down; edges ignored meanwhile
         if (key_edge && running && !stepping_q && !wake_pend_q) begin
            stepping_q <= 1'b1;
         end
         // Resume input, or an unmasked wake source, arms the wake
         if (resume_in || (asleep && !temp_on_q && other_wake)) begin
            wake_pend_q <= 1'b1;
         end
         // In Temporary-On one edge is held back
         if (key_edge && temp_on_q) begin
            buffered_q <= 1'b1;
         end
         if (wr_cause && temp_on_q) begin
            exit_temp_q <= 1'b1;
         end
         if (ref_tick) begin
            if (do_wake) begin
               mode_q      <= `PSR_MODE_HS;
               wake_pend_q <= 1'b0;
               s2s_cnt_q   <= 8'h00;
            end else if (stepping_q) begin
               if (mode_q == `PSR_MODE_DOZE) begin
                  stepping_q <= 1'b0;
               end
               mode_q <= mode_q + 3'h1;
            end else if (exit_temp_q) begin
               temp_on_q   <= 1'b0;
               exit_temp_q <= 1'b0;
               mode_q      <= `PSR_MODE_SUSPEND;
               // The held edge is now handled as a fresh resume
               if (buffered_q || key_edge) begin
                  wake_pend_q <= 1'b1;
                  buffered_q  <= 1'b0;
               end
            end else if (s2s_expire) begin
               temp_on_q <= 1'b1;
               s2s_cnt_q <= 8'h00;
            end else if (mode_q == `PSR_MODE_SLEEP && !temp_on_q) begin
               s2s_cnt_q <= s2s_cnt_q + 8'h01;
            end
         end
      end
   end

   // Auto low-speed window: trigger count, then low-speed duration
   always @(posedge sys_clk) begin
      if (!rst_n || !power_off_request_pin_n || !thr_on) begin
         thr_cnt_q <= 4'h0;
         thr_low_q <= 1'b0;
      end else if (ref_tick) begin
         // Both counted window edges fall on a refresh; dropping thr_on ends the window in any cycle
         if (!thr_low_q && thr_cnt_q >= throttle_q[3:0]) begin
            thr_low_q <= 1'b1;
            thr_cnt_q <= 4'h0;
         end else if (thr_low_q && thr_cnt_q >= throttle_q[7:4]) begin
            thr_low_q <= 1'b0;
            thr_cnt_q <= 4'h0;
         end else begin
            thr_cnt_q <= thr_cnt_q + 4'h1;
         end
      end
   end

   // Registered outputs
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         smi_req_q          <= 1'b0;
         nmi_req_q          <= 1'b0;
         pmu_mode_q         <= `PSR_MODE_HS;
         cpu_clk_run_q      <= 1'b1;
         cpu_low_speed_q    <= 1'b0;
         hs_clk_allow_q     <= 1'b0;
         refresh_toggle_q   <= 1'b0;
         micro_power_off_q  <= 1'b0;
         self_refresh_sel_q <= 1'b0;
         dram_retain_q      <= 1'b0;
         smm_base_q         <= 10'h000;
      end else begin
         smi_req_q  <= req_q && smm_upper_q[`PSR_BIT_SMI_SEL];
         nmi_req_q  <= req_q && !smm_upper_q[`PSR_BIT_SMI_SEL];
         pmu_mode_q <= mode_q;
         // Temporary-On restarts the clock while the mode stays asleep
         cpu_clk_run_q   <= running || temp_on_q;
         cpu_low_speed_q <= temp_on_q || thr_low_q || (mode_q == `PSR_MODE_LS);
         // High speed needs its own enable and HS mode; the window only takes it away
         hs_clk_allow_q  <= io_wait_q[`PSR_BIT_HS_CLK_EN] && (mode_q == `PSR_MODE_HS) &&
                            !thr_low_q && !temp_on_q;
         if (ref_tick) begin
            refresh_toggle_q <= ~refresh_toggle_q;
         end
         micro_power_off_q  <= !power_off_request_pin_n;
         // Refresh type kept through the outage from its preset value
         self_refresh_sel_q <= misc5_q[`PSR_BIT_SELF_REF];
         dram_retain_q      <= misc3_q[`PSR_BIT_DRAM_KEEP];
         smm_base_q         <= {smm_upper_q[5:4], smm_lower_q};
      end
   end

endmodule
`default_nettype wire

/* tb/psr_pmu_checker.sv */
// Port-level checks for the suspend/resume sequencer
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.vh"

module psr_pmu_checker (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       power_off_request_pin_n,
   input wire logic       refresh_pulse,
   input wire logic       cfg_index_we,
   input wire logic       cfg_data_we,
   input wire logic [7:0] cfg_wdata,
   input wire logic       smi_req_q,
   input wire logic       nmi_req_q,
   input wire logic [2:0] pmu_mode_q,
   input wire logic       temp_on_q,
   input wire logic       cpu_clk_run_q,
   input wire logic       cpu_low_speed_q,
   input wire logic       refresh_toggle_q,
   input wire logic       micro_power_off_q,
   input wire logic       self_refresh_sel_q,
   input wire logic       dram_retain_q
);
   logic [7:0] idx_q;
   logic [3:0] rp_age_q;
   logic [3:0] po_age_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Shadow index and ages; outputs jump at a partial reset, so those cycles are skipped
   always @(posedge sys_clk) begin
      idx_q    <= (!rst_n || !power_off_request_pin_n) ? 8'h00 : cfg_index_we ? cfg_wdata : idx_q;
      rp_age_q <= (!rst_n || refresh_pulse) ? 4'h0 : rp_age_q + {3'h0, rp_age_q != 4'hF};
      po_age_q <= (!rst_n || !power_off_request_pin_n) ? 4'h0 : po_age_q + {3'h0, po_age_q != 4'hF};
   end

   a_mode_steps: assert property ($changed(pmu_mode_q) && po_age_q > 4'h3 |->
      pmu_mode_q == $past(pmu_mode_q) + 3'h1 || pmu_mode_q == `PSR_MODE_HS)
      else $error("mode moved other than one step or a wake");
   a_toggle_paced: assert property ($changed(refresh_toggle_q) && po_age_q > 4'h3 |->
      rp_age_q < 4'h8) else $error("toggle without refresh");
   a_req_held: assert property (smi_req_q && !cfg_data_we && !$past(cfg_data_we)
      && power_off_request_pin_n |=> smi_req_q) else $error("request dropped");
   a_req_cleared: assert property (cfg_data_we && idx_q == `PSR_IDX_REQ_STAT
      && rp_age_q > 4'h8 |-> ##[1:2] !smi_req_q && !nmi_req_q) else $error("request kept");
   a_one_request: assert property (!(smi_req_q && nmi_req_q))
      else $error("both requests");
   a_power_off: assert property (!power_off_request_pin_n |=> micro_power_off_q)
      else $error("power-off late");
   a_temp_on_clk: assert property (temp_on_q && $past(temp_on_q) |->
      cpu_clk_run_q && cpu_low_speed_q) else $error("temp-on clock wrong");
   a_keep_dram: assert property (!power_off_request_pin_n && !cfg_data_we |=>
      $stable(dram_retain_q) && $stable(self_refresh_sel_q)) else $error("kept bit lost");

   c_temp_on: cover property ($rose(temp_on_q));
   c_suspend: cover property (pmu_mode_q == `PSR_MODE_SUSPEND);
   c_power_off: cover property ($rose(micro_power_off_q));
endmodule

bind psr_pmu_seq psr_pmu_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
   .power_off_request_pin_n(power_off_request_pin_n), .refresh_pulse(refresh_pulse),
   .cfg_index_we(cfg_index_we), .cfg_data_we(cfg_data_we), .cfg_wdata(cfg_wdata),
   .smi_req_q(smi_req_q), .nmi_req_q(nmi_req_q), .pmu_mode_q(pmu_mode_q),
   .temp_on_q(temp_on_q), .cpu_clk_run_q(cpu_clk_run_q), .cpu_low_speed_q(cpu_low_speed_q),
   .refresh_toggle_q(refresh_toggle_q), .micro_power_off_q(micro_power_off_q),
   .self_refresh_sel_q(self_refresh_sel_q), .dram_retain_q(dram_retain_q));
`default_nettype wire

/* tb/psr_cpu_model.sv */
// Behavioural CPU core that takes the level SMI request and runs a handler
`timescale 1ns/1ps
`default_nettype none

module psr_cpu_model (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       smi_req,
   input  wire logic       ret_req,
   input  wire logic [3:0] entry_dly,
   output var  logic       cpu_in_smm
);
   logic [3:0] wait_q;

   // Request ignored inside a handler; only reset or a commanded return re-arms it
   always @(posedge sys_clk) begin
      if (!rst_n || ret_req) begin
         cpu_in_smm <= 1'b0;
         wait_q     <= 4'h0;
      end else if (smi_req && !cpu_in_smm) begin
         wait_q     <= wait_q + 4'h1;
         cpu_in_smm <= wait_q >= entry_dly;
      end
   end
endmodule
`default_nettype wire

/* tb/psr_pmu_seq_test.sv */
// Self-checking bench for the suspend/resume sequencer
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.vh"

module psr_pmu_seq_test;
   logic       sys_clk, rst_n, key, pwr_n, rfsh, ret, in_smm, idx_we, dat_we, dat_re;
   logic       smi, nmi, temp_on, clk_run, low_spd, hs_ok, tgl, mpo, sref, dkeep;
   logic [3:0] dly;
   logic [7:0] wake, act, wdata, rdata;
   logic [2:0] mode;
   logic [9:0] base;
   int         errors = 0;
   int         n_tests = 0;
   int         cyc = 0;

   psr_pmu_seq dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .suspend_resume_key_input(key),
      .power_off_request_pin_n(pwr_n), .refresh_pulse(rfsh), .cpu_in_smm(in_smm),
      .wake_event_in(wake), .activity_in(act), .cfg_index_we(idx_we), .cfg_data_we(dat_we),
      .cfg_data_re(dat_re), .cfg_wdata(wdata), .cfg_rdata_q(rdata), .smi_req_q(smi),
      .nmi_req_q(nmi), .pmu_mode_q(mode), .temp_on_q(temp_on), .cpu_clk_run_q(clk_run),
      .cpu_low_speed_q(low_spd), .hs_clk_allow_q(hs_ok), .refresh_toggle_q(tgl),
      .micro_power_off_q(mpo), .self_refresh_sel_q(sref), .dram_retain_q(dkeep),
      .smm_base_q(base));
   psr_cpu_model cpu_u (.sys_clk(sys_clk), .rst_n(rst_n), .smi_req(smi), .ret_req(ret),
      .entry_dly(dly), .cpu_in_smm(in_smm));

   // Free-running 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Index then data on back-to-back edges
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge sys_clk);
      idx_we <= 1'b1;
      wdata  <= i;
      @(posedge sys_clk);
      idx_we <= 1'b0;
      dat_we <= 1'b1;
      wdata  <= d;
      @(posedge sys_clk);
      dat_we <= 1'b0;
   endtask

   // Read data is taken just after the edge that loads it
   task automatic rdc(input logic [7:0] i, input logic [7:0] e);
      @(posedge sys_clk);
      idx_we <= 1'b1;
      wdata  <= i;
      @(posedge sys_clk);
      idx_we <= 1'b0;
      dat_re <= 1'b1;
      @(posedge sys_clk);
      dat_re <= 1'b0;
      #1 chk({2'b00, rdata}, {2'b00, e});
   endtask

   // One refresh pulse, long enough for the two-stage sync
   task automatic tick;
      logic t0;
      t0 = tgl;
      @(posedge sys_clk);
      rfsh <= 1'b1;
      cyc_n(2);
      rfsh <= 1'b0;
      cyc_n(10);
      chk(tgl, !t0);
   endtask

   task automatic press;
      @(posedge sys_clk);
      key <= 1'b1;
      cyc_n(4);
      key <= 1'b0;
      cyc_n(6);
   endtask

   // Suspend edge, then one step per refresh; a second edge mid-way must be ignored
   task automatic go_sleep;
      press;
      for (int i = 1; i < 4; i++) begin
         tick;
         chk(mode, i[9:0]);
         if (i == 1)
            press;
      end
   endtask

   task automatic t_regs;
      rdc(`PSR_IDX_REVISION, `PSR_RST_REVISION);
      rdc(`PSR_IDX_EVT_EN, `PSR_RST_REG);
      wr(8'h10, 8'hFF);
      rdc(8'h10, 8'h00);
      wr(`PSR_IDX_S2S_TMO, 8'h01);
      wr(`PSR_IDX_EVT_EN, 8'h09);
      wr(`PSR_IDX_SMM_UPPER, 8'hB0);
      wr(`PSR_IDX_SMM_LOWER, 8'h5A);
      wr(`PSR_IDX_WAKE_MASK, 8'hFF);
      wr(`PSR_IDX_ACT_MASK, 8'hFF);
      rdc(`PSR_IDX_S2S_TMO, 8'h01);
      chk(base, 10'h35A);
   endtask

   task automatic t_suspend;
      dly <= 4'h9;
      go_sleep;
      tick;
      chk({temp_on, clk_run, low_spd, smi}, 4'hF);
      cyc_n(12);
      rdc(`PSR_IDX_REVISION, 8'h83);
      rdc(`PSR_IDX_SMI_CAUSE, 8'h08);
      wr(`PSR_IDX_REQ_STAT, 8'h00);
      cyc_n(2);
      chk(smi, 1'b0);
      press;
      tick;
      chk({mode, temp_on}, {`PSR_MODE_SLEEP, 1'b1});
      wr(`PSR_IDX_SMI_CAUSE, 8'h00);
      rdc(`PSR_IDX_SMI_CAUSE, 8'h00);
      tick;
      chk({mode, temp_on}, {`PSR_MODE_SUSPEND, 1'b0});
      tick;
      chk({mode, smi}, {`PSR_MODE_HS, 1'b1});
      rdc(`PSR_IDX_SMI_CAUSE, 8'h01);
      wr(`PSR_IDX_REQ_STAT, 8'h00);
      wr(`PSR_IDX_SMI_CAUSE, 8'h00);
      // Handler returns only now, after the wake
      ret <= 1'b1;
      @(posedge sys_clk);
      ret <= 1'b0;
   endtask

   // Masked wake sources, resume enable off and on, routed as the other request kind
   task automatic t_resume;
      for (int i = 0; i < 2; i++) begin
         dly <= 4'h0;
         wr(`PSR_IDX_S2S_TMO, 8'h00);
         wr(`PSR_IDX_EVT_EN, i[7:0]);
         wr(`PSR_IDX_SMM_UPPER, 8'h30);
         go_sleep;
         wake <= 8'hFF;
         act  <= 8'hFF;
         tick;
         chk(mode, `PSR_MODE_SLEEP);
         press;
         tick;
         chk({mode, nmi, smi}, {`PSR_MODE_HS, i[0], 1'b0});
         wake <= 8'h00;
         act  <= 8'h00;
         wr(`PSR_IDX_REQ_STAT, 8'h00);
         wr(`PSR_IDX_SMI_CAUSE, 8'h00);
      end
   endtask

   task automatic t_throttle;
      logic seen;
      seen = 1'b0;
      wr(`PSR_IDX_IO_WAIT, 8'h40);
      wr(`PSR_IDX_THROTTLE, 8'h11);
      tick;
      chk(hs_ok, 1'b1);
      wr(`PSR_IDX_CTRL_B, 8'h08);
      repeat (4) begin
         tick;
         seen = seen | !hs_ok;
      end
      chk(seen, 1'b1);
   endtask

   task automatic t_power;
      wr(`PSR_IDX_MISC5, 8'h08);
      wr(`PSR_IDX_MISC3, 8'h1F);
      wr(`PSR_IDX_CLK_SET, 8'h5A);
      @(posedge sys_clk);
      pwr_n <= 1'b0;
      cyc_n(3);
      chk({mpo, sref, dkeep}, 3'h7);
      pwr_n <= 1'b1;
      cyc_n(3);
      rdc(`PSR_IDX_MISC3, 8'h1F);
      rdc(`PSR_IDX_CLK_SET, 8'h5A);
      rdc(`PSR_IDX_CTRL_B, 8'h00);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      cyc_n(2);
      rst_n <= 1'b1;
      cyc_n(2);
      chk(dkeep, 1'b0);
   endtask

   task automatic complete_run;
      $display("comparisons=%0d mismatches=%0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Hang guard: the whole run needs well under two thousand cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         complete_run;
      end
   end

   initial begin
      {rst_n, key, rfsh, ret, idx_we, dat_we, dat_re} = 7'h00;
      pwr_n = 1'b1;
      dly   = 4'h0;
      {wake, act, wdata} = 24'h00_0000;
      cyc_n(20);
      rst_n <= 1'b1;
      t_regs;
      $display("register test done");
      t_suspend;
      $display("suspend test done");
      t_resume;
      $display("resume test done");
      t_throttle;
      $display("throttle test done");
      t_power;
      $display("power-off test done");
      complete_run;
   end
endmodule
`default_nettype wire
